// *** pkg/csod_pkg.sv ***
// Purpose: shared constants and decoders of the storage operand datapath
// Assumes: clk_sys at 100 MHz; registers sit on a classic Wishbone slave
// Notes: byte addresses of registers; storage is big-endian, bit 0 leftmost
package csod_pkg;
   // Timing
   localparam int CLK_NS    = 10;
   localparam int STORE_NS  = 600;
   localparam int STORE_CYC = (STORE_NS + CLK_NS - 1) / CLK_NS;
   // Storage layout
   localparam int          MEM_BYTES_MAX = 131072;
   localparam logic [16:0] LOW_LIMIT     = 17'h00200;
   localparam logic [16:0] GR_PRIV_BASE  = 17'h00100;
   localparam logic [16:0] GR_PROB_BASE  = 17'h00140;
   // Register offsets
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_ADDR  = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_CMD   = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_STAT  = 8'h14;
   localparam logic [7:0] REG_LO    = 8'h18;
   localparam logic [7:0] REG_HI    = 8'h1C;
   localparam logic [7:0] REG_IDX1  = 8'h20;
   localparam logic [7:0] REG_IDX2  = 8'h24;
   // Reset values
   localparam logic [1:0]  CTRL_RST = 2'h1;
   localparam logic [16:0] LO_RST   = 17'h00000;
   localparam logic [16:0] HI_RST   = 17'h1FFFF;
   // Field positions
   localparam int CTL_PRIV = 0;
   localparam int CTL_EBC  = 1;
   localparam int CMD_IX1  = 10;
   localparam int CMD_IX2  = 11;
   localparam int CMD_DAR  = 12;
   localparam int F_SPEC   = 1;
   localparam int F_ADR    = 2;
   localparam int F_PROT   = 3;
   localparam int F_PAR    = 4;
   localparam int F_PRIV   = 5;
   localparam int F_OVF    = 6;
   localparam int F_DEC    = 7;
   // Commands
   localparam logic [3:0] OP_RDB = 4'h0, OP_RDH = 4'h1, OP_RDF = 4'h2, OP_RDHS = 4'h3;
   localparam logic [3:0] OP_WRB = 4'h4, OP_WRH = 4'h5, OP_WRF = 4'h6, OP_IFET = 4'h7;
   localparam logic [3:0] OP_RGR = 4'h8, OP_WGR = 4'h9, OP_ADD = 4'hA, OP_LOGR = 4'hB;
   localparam logic [3:0] OP_LOGS = 4'hC, OP_DCHK = 4'hD;
   // Operand size: 0 byte, 1 halfword, 2 fullword
   function automatic logic [1:0] op_size(input logic [3:0] op);
      unique case (op)
         OP_RDB, OP_WRB, OP_LOGS, OP_DCHK: op_size = 2'h0;
         OP_RDH, OP_RDHS, OP_WRH, OP_IFET: op_size = 2'h1;
         default:                          op_size = 2'h2;
      endcase
   endfunction
   function automatic logic op_wr(input logic [3:0] op);
      op_wr = op inside {OP_WRB, OP_WRH, OP_WRF, OP_WGR, OP_ADD, OP_LOGR, OP_LOGS};
   endfunction
   function automatic logic op_gr(input logic [3:0] op);
      op_gr = op inside {OP_RGR, OP_WGR, OP_ADD, OP_LOGR};
   endfunction
   function automatic logic sign_minus(input logic [3:0] n);
      sign_minus = (n == 4'hB) || (n == 4'hD);
   endfunction
endpackage

// *** logic/csod_store.sv ***
// Purpose: main storage array, one halfword per access, odd byte parity
// Assumes: req is ignored while an access runs
// Notes: read data and parity check appear together with done
`timescale 1ns/1ps
`default_nettype none
module csod_store #(
   parameter int DEPTH_HW = csod_pkg::MEM_BYTES_MAX / 2
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Request
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [1:0]  be,
   input  wire logic [15:0] hw_addr,
   input  wire logic [15:0] wdata,
   // Answer
   output logic             done,
   output logic [15:0]      rdata,
   output logic             perr
);
   import csod_pkg::*;
   localparam int LAT = STORE_CYC;
   logic [8:0]  mem_hi [DEPTH_HW];
   logic [8:0]  mem_lo [DEPTH_HW];
   logic        busy_q, we_q;
   logic [1:0]  be_q;
   logic [15:0] a_q, wd_q;
   logic [7:0]  cnt_q;
   initial begin
      if (DEPTH_HW < 1 || DEPTH_HW > 65536 || STORE_CYC < 2 || STORE_CYC > 255)
         $error("csod_store: unsupported depth or cycle count");
   end
   // Access control
   wire go  = req && !busy_q;
   wire fin = busy_q && (cnt_q == 8'h00);
   wire [8:0] rd_hi = mem_hi[a_q];
   wire [8:0] rd_lo = mem_lo[a_q];
   // RULE22 - read parity check
   wire bad = (be_q[1] && !(^rd_hi)) || (be_q[0] && !(^rd_lo));
   // Sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
         we_q   <= 1'b0;
         be_q   <= 2'h0;
         a_q    <= 16'h0000;
         wd_q   <= 16'h0000;
         cnt_q  <= 8'h00;
         done   <= 1'b0;
         rdata  <= 16'h0000;
         perr   <= 1'b0;
      end else begin
         done <= fin;
         perr <= fin && !we_q && bad;
         if (go) begin
            busy_q <= 1'b1;
            we_q   <= we;
            be_q   <= be;
            a_q    <= hw_addr;
            wd_q   <= wdata;
            // RULE1 - halfword cycle time
            cnt_q  <= 8'(STORE_CYC - 2);
         end else if (fin) begin
            busy_q <= 1'b0;
            rdata  <= {rd_hi[7:0], rd_lo[7:0]};
         end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
   // RULE2 - parity makes ones odd
   // RULE3 - parity generated on write
   always_ff @(posedge clk_sys) begin
      if (fin && we_q && be_q[1]) begin
         mem_hi[a_q] <= {~^wd_q[15:8], wd_q[15:8]};
      end
      if (fin && we_q && be_q[0]) begin
         mem_lo[a_q] <= {~^wd_q[7:0], wd_q[7:0]};
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   store_time_a: assert property (go |-> ##LAT done) // RULE1
      else $error("storage access did not end on time");
   odd_parity_a: assert property (done && we_q && be_q[1] |-> ^mem_hi[a_q]) // RULE2
      else $error("stored byte parity is not odd");
endmodule // csod_store
`default_nettype wire

// *** logic/csod_dec.sv ***
// Purpose: decimal byte decoder for packed and unpacked operands
// Assumes: byte is the least significant byte of a decimal field
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module csod_dec (
   // Operand
   input  wire logic [7:0] byte_i,
   input  wire logic       ebc_i,
   // Results
   output logic            zone_minus,
   output logic            pack_minus,
   output logic            pack_ok,
   output logic [3:0]      sign_code
);
   import csod_pkg::*;
   // RULE15 - zone carries unpacked sign
   assign zone_minus = sign_minus(byte_i[7:4]);
   // RULE16 - low nibble is packed sign
   assign pack_minus = sign_minus(byte_i[3:0]);
   // RULE17 - digit and sign codes
   assign pack_ok    = (byte_i[7:4] <= 4'h9) && (byte_i[3:0] >= 4'hA);
   // RULE18 - mode picks sign codes
   assign sign_code  = ebc_i ? (pack_minus ? 4'hD : 4'hC) : (pack_minus ? 4'hB : 4'hA);
endmodule // csod_dec
`default_nettype wire

// *** logic/csod_core.sv ***
// Purpose: storage operand datapath behind a classic Wishbone slave
// Assumes: 100 MHz clk_sys, asynchronous active-low reset_n
// Notes: one command at a time; CMD writes while busy are ignored
// Summary of operation
// RULE1 - Storage performs one halfword access per 600 ns cycle.
// RULE2 - Each byte holds eight data bits plus an odd parity bit.
// RULE3 - Parity is made on every write and never visible to software.
// RULE4 - Byte addresses run from zero upward; operands use their leftmost byte.
// RULE5 - Bit zero is the leftmost, most significant bit.
// RULE6 - Halfwords sit on even addresses, fullwords on multiples of four.
// RULE7 - Instructions are two, four or six bytes on even addresses.
// RULE8 - The lowest 512 bytes hold fixed operating information.
// RULE9 - Writes outside the bound registers are blocked and flagged. General register writes are not checked against them.
// RULE10 - Two banks of 16 general registers in low storage, chosen by mode.
// RULE11 - General registers are 32 bits, selected by a 4-bit number.
// RULE12 - Twos complement adder; single or double indexing of addresses.
// RULE13 - Fixed-point operands are 32 or 16 bits, sign leftmost.
// RULE14 - Halfword operands are right-justified and sign extended.
// RULE15 - Unpacked bytes carry zone and digit; last zone is the sign.
// RULE16 - Packed bytes carry two digits; decimal arithmetic needs packed.
// RULE17 - Codes 0-9 are digits; 1011 and 1101 minus, others plus.
// RULE18 - A mode bit chooses 1010/1011 or 1100/1101 sign codes.
// RULE19 - Fixed-length logic works in registers, variable-length in storage.
// RULE20 - Misaligned operand or instruction raises a specification exception.
// RULE21 - Problem-mode reference to low storage raises an addressing exception.
// RULE22 - Every read rechecks parity and flags storage parity errors.
// RULE23 - Bound registers are writable only in privileged mode.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module csod_core #(
   parameter int MEM_BYTES = csod_pkg::MEM_BYTES_MAX
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   import csod_pkg::*;
   typedef enum logic [2:0] {S_IDLE, S_CHK, S_RD, S_ALU, S_WR, S_FIN} csod_state_e;
   csod_state_e state_q;
   logic [1:0]  ctrl_q;
   logic [16:0] addr_q, lo_q, hi_q, ea_q;
   logic [31:0] wdata_q, rdata_q, idx1_q, idx2_q, data_q, wbuf_q;
   logic [15:0] cmd_q;
   logic [7:0]  flags_q;
   logic [1:0]  ilen_q;
   logic [2:0]  dec_q;
   logic        idx_q, pend_q, req_q;
   logic        st_done, st_perr, d_zm, d_pm, d_ok;
   logic [15:0] st_rd;
   logic [3:0]  d_code;
   initial begin
      if (MEM_BYTES < 1024 || MEM_BYTES > MEM_BYTES_MAX || MEM_BYTES % 4 != 0)
         $error("csod_core: unsupported storage size");
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         o[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
      merge = o;
   endfunction

   // Logical function: and, or, exclusive or, move
   function automatic logic [31:0] logic_fn(input logic [1:0] f, input logic [31:0] a,
                                            input logic [31:0] b);
      unique case (f)
         2'h0: logic_fn = a & b;
         2'h1: logic_fn = a | b;
         2'h2: logic_fn = a ^ b;
         2'h3: logic_fn = b;
      endcase
   endfunction

   // Bus decode
   wire        acc   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wr_en = acc && wb_we_i;
   wire [7:0]  a8    = {wb_adr_i[7:2], 2'b00};
   wire        idle  = (state_q == S_IDLE);
   wire        priv  = ctrl_q[CTL_PRIV];
   wire        w_ctl = wr_en && a8 == REG_CTRL;
   wire        w_adr = wr_en && a8 == REG_ADDR;
   wire        w_wd  = wr_en && a8 == REG_WDATA;
   wire        w_cmd = wr_en && a8 == REG_CMD && idle && wb_sel_i[0];
   wire        w_st  = wr_en && a8 == REG_STAT;
   wire        w_lo  = wr_en && a8 == REG_LO;
   wire        w_hi  = wr_en && a8 == REG_HI;
   wire        w_i1  = wr_en && a8 == REG_IDX1;
   wire        w_i2  = wr_en && a8 == REG_IDX2;
   wire [31:0] stat  = {16'h0, 1'b0, dec_q, 2'b00, ilen_q, flags_q[7:1], !idle};
   wire [31:0] rd_mux = a8 == REG_CTRL  ? {30'h0, ctrl_q} :
                        a8 == REG_ADDR  ? {15'h0, addr_q} :
                        a8 == REG_WDATA ? wdata_q :
                        a8 == REG_CMD   ? {16'h0, cmd_q} :
                        a8 == REG_RDATA ? rdata_q :
                        a8 == REG_STAT  ? stat :
                        a8 == REG_LO    ? {15'h0, lo_q} :
                        a8 == REG_HI    ? {15'h0, hi_q} :
                        a8 == REG_IDX1  ? idx1_q :
                        a8 == REG_IDX2  ? idx2_q : 32'h0;

   // Command decode
   wire [3:0]  op    = cmd_q[3:0];
   wire [1:0]  sz    = op_size(op);
   wire        is_gr = op_gr(op);
   wire        is_wr = op_wr(op);
   wire        is_rd = (op != OP_WRB) && (op != OP_WRH) && (op != OP_WRF) && (op != OP_WGR);
   // RULE12 - single or double indexing
   wire [31:0] ea_sum = {15'h0, addr_q} + (cmd_q[CMD_IX1] ? idx1_q : 32'h0)
                        + (cmd_q[CMD_IX2] ? idx2_q : 32'h0);
   // RULE10 - bank chosen by mode
   // RULE11 - 4-bit register number
   wire [16:0] gr_ea = (priv ? GR_PRIV_BASE : GR_PROB_BASE) + {11'h0, cmd_q[7:4], 2'b00};
   // RULE4 - leftmost byte addresses operand
   wire [16:0] ea_w  = is_gr ? gr_ea : ea_sum[16:0];
   wire [16:0] ea_l  = ea_w + {15'h0, sz == 2'h2 ? 2'h3 : {1'b0, sz[0]}};
   // RULE6 - integral boundary check
   // RULE7 - instructions on even addresses
   // RULE20 - specification exception
   wire c_spec = (sz == 2'h2 && ea_w[1:0] != 2'b00) || (sz == 2'h1 && ea_w[0])
                 || (op > OP_DCHK);
   // RULE4 - address range
   // RULE8 - reserved low area
   // RULE21 - low area in problem mode
   wire c_adr  = !is_gr && (ea_sum >= 32'(MEM_BYTES) || (!priv && ea_w < LOW_LIMIT));
   // RULE9 - storage writes checked; general register writes and reads not
   wire c_prot = is_wr && !is_gr && (ea_w < lo_q || ea_l > hi_q);
   wire c_any  = c_spec || c_adr || c_prot;

   // Storage request fields
   wire        last  = idx_q == (sz == 2'h2);
   wire [15:0] hw_a  = ea_q[16:1] + {15'h0, idx_q};
   // RULE5 - even byte is the leftmost
   wire [1:0]  be    = sz == 2'h0 ? (ea_q[0] ? 2'b01 : 2'b10) : 2'b11;
   wire [15:0] wd    = sz == 2'h2 ? (idx_q ? wbuf_q[15:0] : wbuf_q[31:16]) :
                       sz == 2'h1 ? wbuf_q[15:0] : {wbuf_q[7:0], wbuf_q[7:0]};
   wire [7:0]  rbyte = ea_q[0] ? st_rd[7:0] : st_rd[15:8];
   // RULE12 - twos complement adder
   wire [32:0] sum   = {data_q[31], data_q} + {wdata_q[31], wdata_q};
   wire        ovf   = sum[32] ^ sum[31];
   // RULE19 - register or storage logic
   wire [31:0] alu   = op == OP_ADD ? sum[31:0] :
                       (op == OP_LOGR || op == OP_LOGS) ? logic_fn(cmd_q[9:8], data_q, wdata_q)
                       : wdata_q;
   // RULE13 - 16 or 32 bit fixed point
   // RULE14 - halfword sign extension
   wire [31:0] res   = op == OP_RDHS ? {{16{data_q[15]}}, data_q[15:0]} :
                       op == OP_DCHK ? {20'h0, d_code, data_q[7:0]} :
                       is_wr ? wbuf_q : data_q;
   wire [1:0]  ilen  = data_q[15:14] == 2'b00 ? 2'h1 : data_q[15:14] == 2'b11 ? 2'h3 : 2'h2;

   // Sticky flag sources
   wire        chk   = state_q == S_CHK;
   wire        fin   = state_q == S_FIN;
   // RULE23 - bounds need privileged mode
   wire        s_prv = (w_lo || w_hi) && !priv;
   // RULE16 - decimal arithmetic needs packed
   wire        s_dec = fin && op == OP_DCHK && cmd_q[CMD_DAR] && !d_ok;
   wire [7:0]  set_v = {s_dec, state_q == S_ALU && op == OP_ADD && ovf, s_prv, st_perr,
                        chk && c_prot, chk && c_adr, chk && c_spec, 1'b0};
   wire [7:0]  clr_v = w_st && wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
   // Byte-lane merged values of the narrow registers
   wire [31:0] m_ctl = merge({30'h0, ctrl_q}, wb_dat_i, wb_sel_i);
   wire [31:0] m_adr = merge({15'h0, addr_q}, wb_dat_i, wb_sel_i);
   wire [31:0] m_cmd = merge({16'h0, cmd_q}, wb_dat_i, wb_sel_i);
   wire [31:0] m_lo  = merge({15'h0, lo_q}, wb_dat_i, wb_sel_i);
   wire [31:0] m_hi  = merge({15'h0, hi_q}, wb_dat_i, wb_sel_i);

   // Storage array
   csod_store #(
      .DEPTH_HW (MEM_BYTES / 2)
   ) u_store (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .req      (req_q),
      .we       (state_q == S_WR),
      .be       (be),
      .hw_addr  (hw_a),
      .wdata    (wd),
      .done     (st_done),
      .rdata    (st_rd),
      .perr     (st_perr)
   );

   // Decimal decoder
   csod_dec u_dec (
      .byte_i     (data_q[7:0]),
      .ebc_i      (ctrl_q[CTL_EBC]),
      .zone_minus (d_zm),
      .pack_minus (d_pm),
      .pack_ok    (d_ok),
      .sign_code  (d_code)
   );

   // Wishbone answer: ack one cycle after the request is seen
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= acc;
         wb_dat_o <= acc && !wb_we_i ? rd_mux : 32'h0;
      end
   end

   // Software registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q  <= CTRL_RST;
         addr_q  <= 17'h0;
         wdata_q <= 32'h0;
         cmd_q   <= 16'h0;
         lo_q    <= LO_RST;
         hi_q    <= HI_RST;
         idx1_q  <= 32'h0;
         idx2_q  <= 32'h0;
         flags_q <= 8'h00;
      end else begin
         if (w_ctl) ctrl_q  <= m_ctl[1:0];
         if (w_adr) addr_q  <= m_adr[16:0];
         if (w_wd)  wdata_q <= merge(wdata_q, wb_dat_i, wb_sel_i);
         if (w_cmd) cmd_q   <= m_cmd[15:0];
         if (w_lo && priv) lo_q <= m_lo[16:0];
         if (w_hi && priv) hi_q <= m_hi[16:0];
         if (w_i1)  idx1_q  <= merge(idx1_q, wb_dat_i, wb_sel_i);
         if (w_i2)  idx2_q  <= merge(idx2_q, wb_dat_i, wb_sel_i);
         // Set wins over a clear in the same cycle
         flags_q <= (flags_q & ~clr_v) | set_v;
      end
   end

   // Operation sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
         ea_q    <= 17'h0;
         idx_q   <= 1'b0;
         pend_q  <= 1'b0;
         req_q   <= 1'b0;
         data_q  <= 32'h0;
         wbuf_q  <= 32'h0;
      end else begin
         req_q <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               if (w_cmd) state_q <= S_CHK;
            end
            S_CHK: begin
               ea_q   <= ea_w;
               idx_q  <= 1'b0;
               data_q <= 32'h0;
               state_q <= c_any ? S_IDLE : is_rd ? S_RD : S_ALU;
            end
            S_RD, S_WR: begin
               if (!pend_q) begin
                  req_q  <= 1'b1;
                  pend_q <= 1'b1;
               end else if (st_done) begin
                  pend_q <= 1'b0;
                  idx_q  <= !idx_q;
                  if (state_q == S_RD) begin
                     data_q <= sz == 2'h0 ? {24'h0, rbyte} : {data_q[15:0], st_rd};
                  end
                  if (last) begin
                     state_q <= (state_q == S_RD && is_wr) ? S_ALU : S_FIN;
                  end
               end
            end
            S_ALU: begin
               wbuf_q  <= alu;
               idx_q   <= 1'b0;
               state_q <= S_WR;
            end
            S_FIN: state_q <= S_IDLE;
         endcase
      end
   end

   // Results of a finished command
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h0;
         ilen_q  <= 2'h0;
         dec_q   <= 3'h0;
      end else if (fin) begin
         rdata_q <= res;
         if (op == OP_IFET) ilen_q <= ilen;
         if (op == OP_DCHK) dec_q <= {d_ok, d_pm, d_zm};
      end
   end

   // Checks
   fw_align_a: assert property (chk && sz == 2'h2 && ea_w[1:0] != 2'b00 // RULE6
      |=> flags_q[F_SPEC] && idle) else $error("misaligned fullword not refused");
   ifetch_odd_a: assert property (chk && op == OP_IFET && ea_w[0] // RULE20
      |=> idle ##1 flags_q[F_SPEC]) else $error("odd instruction fetch not flagged");
   low_area_a: assert property (chk && !is_gr && !priv && ea_w < LOW_LIMIT // RULE21
      |=> flags_q[F_ADR] && !req_q) else $error("problem-mode low reference allowed");
   write_bound_a: assert property (chk && c_prot |=> idle ##1 !req_q) // RULE9
      else $error("write outside bounds not blocked");
   bound_priv_a: assert property (wr_en && a8 == REG_LO && !priv // RULE23
      |=> $stable(lo_q) && flags_q[F_PRIV]) else $error("bound write in problem mode");
   sign_ext_a: assert property (fin && op == OP_RDHS // RULE14
      |=> rdata_q[31:16] == {16{rdata_q[15]}}) else $error("halfword not sign extended");
   gr_bank_a: assert property (state_q == S_RD && req_q && is_gr // RULE10
      |-> hw_a[15:5] == (priv ? GR_PRIV_BASE[16:6] : GR_PROB_BASE[16:6]))
      else $error("wrong general register bank");
   add_ovf_a: assert property (state_q == S_ALU && op == OP_ADD // RULE12
      && data_q[31] == wdata_q[31] && sum[31] != data_q[31] |=> flags_q[F_OVF])
      else $error("adder overflow missed");
   wb_ack_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle");
   // Range, bound, decimal and instruction length checks
   addr_range_a: assert property (chk && !is_gr && ea_sum >= 32'(MEM_BYTES) // RULE4
      |=> flags_q[F_ADR] && idle) else $error("address beyond storage not refused");
   hi_priv_a: assert property (wr_en && a8 == REG_HI && !priv // RULE23
      |=> $stable(hi_q) && flags_q[F_PRIV]) else $error("upper bound set in problem mode");
   dec_mode_a: assert property (fin && op == OP_DCHK // RULE18
      |-> d_code[3:1] == (ctrl_q[CTL_EBC] ? 3'h6 : 3'h5)) else $error("bad sign mode");
   dec_err_a: assert property (fin && op == OP_DCHK && cmd_q[CMD_DAR] && !d_ok // RULE16
      |=> flags_q[F_DEC]) else $error("unpacked decimal operand not flagged");
   zone_sign_a: assert property (fin && op == OP_DCHK // RULE15
      |=> dec_q[0] == (rdata_q[7:4] inside {4'hB, 4'hD})) else $error("zone sign wrong");
   ifetch_len_a: assert property (fin && op == OP_IFET && data_q[15:14] == 2'b11 // RULE7
      |=> ilen_q == 2'h3) else $error("six-byte instruction length wrong");
   full_write_c: cover property (state_q == S_WR && sz == 2'h2 && st_done && last);
   prot_blk_c: cover property (chk && c_prot);
   add_op_c: cover property (fin && op == OP_ADD);
   spec_exc_c: cover property (chk && c_spec);
   dec_chk_c: cover property (fin && op == OP_DCHK && d_ok);
endmodule // csod_core
`default_nettype wire

// *** sim/csod_wb_master.sv ***
// Purpose: Wishbone classic master model that drives the datapath registers
// Assumes: one request at a time; the bench watchdog bounds every wait
// Notes: signals change only right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module csod_wb_master (
   // Clock
   input  wire logic        clk_sys,
   // Bus
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dat_o,
   input  wire logic        ack,
   input  wire logic [31:0] dat_i
);
   // Idle bus at time zero
   initial begin
      {cyc, stb, we, adr, sel, dat_o} = '0;
   end
   // One classic cycle; the request stands until ack is sampled high
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
      @(posedge clk_sys);
      {cyc, stb, we, adr, sel, dat_o} <= {2'b11, w, a, 4'hF, d};
      do begin
         @(posedge clk_sys);
      end while (ack !== 1'b1);
      q = dat_i;
      {cyc, stb} <= 2'b00;
   endtask
endmodule // csod_wb_master
`default_nettype wire

// *** sim/csod_core_tb_top.sv ***
// Purpose: self-checking bench of the storage operand datapath
// Assumes: commands are polled until busy clears
// Notes: random data from a fixed seed, corner cases mixed in
`timescale 1ns/1ps
`default_nettype none
module csod_core_tb_top;
   import csod_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic cyc, stb, we, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dw, dr, rd, st, v, d, q;
   logic [16:0] a;
   int err_total = 0;
   int n_compared = 0;
   // Clock at 100 MHz
   always #5 clk_sys = ~clk_sys;
   csod_core u_csod_core (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
      .wb_dat_o(dr), .wb_ack_o(ack));
   csod_wb_master u_csod_wb_master (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we),
      .adr(adr), .sel(sel), .dat_o(dw), .ack(ack), .dat_i(dr));
   task automatic rw(input logic [7:0] ad, input logic [31:0] x);
      u_csod_wb_master.access(1'b1, ad, x, v);
   endtask
   task automatic rr(input logic [7:0] ad, output logic [31:0] x);
      u_csod_wb_master.access(1'b0, ad, 32'h0, x);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Clears flags, loads operands, starts a command and waits for idle
   task automatic run(input logic [15:0] c, input logic [16:0] ad, input logic [31:0] x);
      rw(REG_STAT, 32'hFE);
      rw(REG_ADDR, {15'h0, ad});
      rw(REG_WDATA, x);
      rw(REG_CMD, {16'h0, c});
      st = 32'h1;
      while (st[0] !== 1'b0) begin
         rr(REG_STAT, st);
      end
      rr(REG_RDATA, rd);
   endtask
   function automatic logic [3:0] pref(input logic e, input logic m);
      pref = e ? (m ? 4'hD : 4'hC) : (m ? 4'hB : 4'hA);
   endfunction
   function automatic logic [31:0] lf(input logic [1:0] f, input logic [31:0] x, y);
      lf = f == 2'h0 ? x & y : f == 2'h1 ? x | y : f == 2'h2 ? x ^ y : y;
   endfunction
   function automatic logic [1:0] il(input logic [1:0] b);
      il = b == 2'b00 ? 2'h1 : b == 2'b11 ? 2'h3 : 2'h2;
   endfunction
   task automatic stop_test;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog
   initial begin
      #800000;
      err_total++;
      stop_test();
   end
   initial begin
      v = $urandom(32'h8da6c636);
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      rr(REG_CTRL, rd); chk(rd, {30'h0, CTRL_RST});
      rr(REG_HI, rd); chk(rd, {15'h0, HI_RST});
      rr(8'h30, rd); chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         a = 17'h00400 + 17'(i * 8);
         d = $urandom();
         d[15] = i[0];
         d[31:30] = 2'(i);
         run(OP_WRF, a, d); chk(st & 32'hFE, 32'h0);
         run(OP_RDF, a, 0); chk(rd, d);
         run(OP_RDB, a, 0); chk(rd, {24'h0, d[31:24]});
         run(OP_RDHS, a + 2, 0); chk(rd, {{16{d[15]}}, d[15:0]});
         run(OP_RDH, a + 2, 0); chk(rd, {16'h0, d[15:0]});
         run(OP_IFET, a, 0); chk(rd, {16'h0, d[31:16]});
         chk(st[9:8], il(d[31:30]));
      end
      run(OP_RDF, 17'h00402, 0); chk(st & 32'hFE, 32'h2);
      run(OP_RDH, 17'h00401, 0); chk(st & 32'hFE, 32'h2);
      run(OP_IFET, 17'h00403, 0); chk(st & 32'hFE, 32'h2);
      rw(REG_IDX1, 32'h10);
      rw(REG_IDX2, 32'h20);
      run(OP_RDF | 16'h0C00, 17'h003E8, 0); chk(rd, d);
      run(OP_RDB | 16'h0400, 17'h1FFF0, 0); chk(st & 32'hFE, 32'h4);
      run(OP_WRB, 17'h00800, 32'h11);
      rw(REG_HI, 32'h007FF);
      run(OP_WRB, 17'h00800, 32'h5A); chk(st & 32'hFE, 32'h8);
      run(OP_RDB, 17'h00800, 0); chk(rd, 32'h11);
      run(OP_WRH, 17'h007FE, 32'h1234); chk(st & 32'hFE, 32'h0);
      rw(REG_HI, {15'h0, HI_RST});
      q = $urandom();
      run(OP_WGR | 16'h0070, 0, q);
      rw(REG_CTRL, 32'h0);
      run(OP_RDB, 17'h001FF, 0); chk(st & 32'hFE, 32'h4);
      rw(REG_STAT, 32'hFE);
      rw(REG_LO, 32'h5);
      rr(REG_STAT, st); chk(st & 32'hFE, 32'h20);
      rr(REG_LO, rd); chk(rd, 32'h0);
      run(OP_WGR | 16'h0070, 0, d);
      run(OP_RGR | 16'h0070, 0, 0); chk(rd, d);
      rw(REG_CTRL, 32'h1);
      run(OP_RGR | 16'h0070, 0, 0); chk(rd, q);
      run(OP_RDF, GR_PROB_BASE + 17'h1C, 0); chk(rd, d);
      for (int f = 0; f < 4; f++) begin
         run(OP_LOGR | 16'h0070 | 16'(f << 8), 0, d);
         run(OP_RGR | 16'h0070, 0, 0); chk(rd, lf(f[1:0], q, d));
         q = rd;
      end
      run(OP_WGR | 16'h0030, 0, 32'h7FFFFFFF);
      run(OP_ADD | 16'h0030, 0, 32'h1); chk(st & 32'hFE, 32'h40);
      for (int s = 10; s < 32; s++) begin
         d = {4'h0, 4'(s % 10), 4'hA + 4'(s % 6)};
         rw(REG_CTRL, {30'h0, s[4], 1'b1});
         run(OP_WRB, 17'h00600, d);
         run(OP_DCHK, 17'h00600, 0);
         chk(rd, {20'h0, pref(s[4], d[3:0] == 4'hB || d[3:0] == 4'hD), d[7:0]});
         chk(st[14:13], {1'b1, d[3:0] == 4'hB || d[3:0] == 4'hD});
      end
      run(OP_WRB, 17'h00600, 32'hB5);
      run(OP_DCHK | 16'h1000, 17'h00600, 0); chk(st & 32'h70FE, 32'h1080);
      run(OP_LOGS | 16'h0200, 17'h00600, 32'hF);
      run(OP_RDB, 17'h00600, 0); chk(rd, 32'hBA);
      stop_test();
   end
endmodule // csod_core_tb_top
`default_nettype wire
